// >>> pkg/rcms_pkg.sv
// Constants for the reset and configuration mode select block
// Function
// R1: External reset pin is active low.
// R2: Monitor disabled: reset follows pin only.
// R3: Monitor enabled: need pin high, supplies stable.
// R4: Supply drop asserts reset again.
// R5: Unconnected monitor enable reads as zero.
// R6: Board releases reset after supplies stable.
// R7: Sample four-bit mode on reset release.
// R8: Codes 0-3 select self-driven SPI.
// R9: Codes 4-7 select externally driven SPI.
// R10: Code C selects boundary-scan configuration.
// R11: Board presents only the nine codes.
// R12: Self-driven SPI reads flash itself.
// R13: External processor drives passive SPI.
// R14: Accept configuration from internal user logic.
// R15: Boundary-scan mode never starts by itself.
// R16: Programmer holds reset while writing flash.
// R17: Programmer resets device before shifting configuration.
// R18: Self-driven SPI starts at reset release.
// R19: Done and failed pins report progress.
// R20: Sampled mode holds until next release.
// R21: Combined reset synchronised before release.
package rcms_pkg;

  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [3:0] MODE_ACTIVE_LO = 4'h0;
  localparam logic [3:0] MODE_ACTIVE_HI = 4'h3;
  localparam logic [3:0] MODE_PASSIVE_LO = 4'h4;
  localparam logic [3:0] MODE_PASSIVE_HI = 4'h7;
  localparam logic [3:0] MODE_SCAN = 4'hC;
  localparam int MODE_W = 4;
  localparam int PHASE_BIT = 0;
  localparam int POLARITY_BIT = 1;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------
  // Decoded configuration source
  // ----------------------------------------
  typedef enum logic [4:0]
  {
    SRC_NONE = 5'h01,
    SRC_ACTIVE = 5'h02,
    SRC_PASSIVE = 5'h04,
    SRC_SCAN = 5'h08,
    SRC_BAD = 5'h10
  } rcms_src_e;

  // ----------------------------------------
  // Configuration progress states
  // ----------------------------------------
  typedef enum logic [4:0]
  {
    ST_RESET = 5'h01,
    ST_LOAD = 5'h02,
    ST_WAIT = 5'h04,
    ST_DONE = 5'h08,
    ST_FAIL = 5'h10
  } rcms_state_e;

  function automatic rcms_src_e rcms_decode(input logic [3:0] code);
    if (code <= MODE_ACTIVE_HI)
      return SRC_ACTIVE;
    else if (code >= MODE_PASSIVE_LO && code <= MODE_PASSIVE_HI)
      return SRC_PASSIVE;
    else if (code == MODE_SCAN)
      return SRC_SCAN;
    else
      return SRC_BAD;
  endfunction : rcms_decode

endpackage : rcms_pkg

// >>> logic/rcms_reset_sync.sv
// Reset combiner and release synchroniser
`timescale 1ns/100ps
module rcms_reset_sync #(
  parameter int STAGES = rcms_pkg::SYNC_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic porEnable,
  input wire logic supplyStable,
  output logic coreReset,
  output logic releasePulse
);
  // A single stage would let the release meet the clock unfiltered
  if (STAGES < 2)
  begin : g_bad_stages
    $error("STAGES must be at least 2");
  end

  logic holdReset;
  logic asyncReset;
  logic [STAGES-1:0] syncChain_r;
  logic coreReset_r;

  // Pin low holds reset; monitor counted only when enabled
  assign holdReset = !resetPinN || (porEnable && !supplyStable); // [R1] [R2] [R3] [R4] [R5]
  assign asyncReset = rst || holdReset;

  // Assert at once, release only after the chain fills
  always_ff @(posedge clk_sys or posedge asyncReset)
  begin
    if (asyncReset)
      syncChain_r <= '0;
    else
      syncChain_r <= {syncChain_r[STAGES-2:0], 1'b1}; // [R21]
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      coreReset_r <= 1'b1;
    else
      coreReset_r <= !syncChain_r[STAGES-1];
  end

  assign coreReset = !syncChain_r[STAGES-1];
  // One clean edge where the last stage has risen
  assign releasePulse = coreReset_r && syncChain_r[STAGES-1]; // [R21]
endmodule : rcms_reset_sync

// >>> logic/rcms_mode_latch.sv
// Mode pin capture and decode
`timescale 1ns/100ps
module rcms_mode_latch #(
  parameter int WIDTH = rcms_pkg::MODE_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic capture,
  input wire logic [WIDTH-1:0] modePins,
  output logic [WIDTH-1:0] modeHeld,
  output rcms_pkg::rcms_src_e source
);
  if (WIDTH != 4)
  begin : g_bad_width
    $error("WIDTH must be 4");
  end

  logic [WIDTH-1:0] modeHeld_r;
  rcms_pkg::rcms_src_e source_r;

  // Only the release edge loads; held otherwise
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      modeHeld_r <= '0;
    else if (capture)
      modeHeld_r <= modePins; // [R7] [R20]
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      source_r <= rcms_pkg::SRC_NONE;
    else if (capture)
      source_r <= rcms_pkg::rcms_decode(modePins); // [R8] [R9] [R10]
  end

  assign modeHeld = modeHeld_r;
  assign source = source_r;
endmodule : rcms_mode_latch

// >>> logic/rcms_top.sv
// Reset and configuration mode select top level
`timescale 1ns/100ps
module rcms_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic porEnable,
  input wire logic supplyStable,
  input wire logic [3:0] config_mode_select,
  input wire logic loadDone,
  input wire logic loadError,
  input wire logic userLoadStart,
  input wire logic failedIn,
  output logic coreReset,
  output logic [3:0] modeHeld,
  output logic spiActive,
  output logic spiPassive,
  output logic scanMode,
  output logic badMode,
  output logic spiPolarity,
  output logic spiPhase,
  output logic flashReadStart,
  output logic userLoadActive,
  output logic cfgDone,
  output logic failedOut,
  output logic failedOe
);

  // ----------------------------------------
  // Reset and mode capture
  // ----------------------------------------
  logic releasePulse;
  rcms_pkg::rcms_src_e source;
  rcms_pkg::rcms_state_e state_r;
  rcms_pkg::rcms_state_e state_nxt;
  logic flashReadStart_r;
  logic userLoad_r;
  logic cfgDone_r;
  logic failedDrive_r;

  rcms_reset_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .resetPinN(resetPinN),
    .porEnable(porEnable),
    .supplyStable(supplyStable),
    .coreReset(coreReset),
    .releasePulse(releasePulse)
  );

  rcms_mode_latch u_mode (
    .clk_sys(clk_sys),
    .rst(rst),
    .capture(releasePulse),
    .modePins(config_mode_select),
    .modeHeld(modeHeld),
    .source(source)
  );

  assign spiActive = (source == rcms_pkg::SRC_ACTIVE);
  assign spiPassive = (source == rcms_pkg::SRC_PASSIVE);
  assign scanMode = (source == rcms_pkg::SRC_SCAN);
  assign badMode = (source == rcms_pkg::SRC_BAD);
  assign spiPhase = modeHeld[rcms_pkg::PHASE_BIT] && (spiActive || spiPassive);
  assign spiPolarity = modeHeld[rcms_pkg::POLARITY_BIT] && (spiActive || spiPassive);

  // ----------------------------------------
  // Progress state machine
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rcms_pkg::ST_RESET:
      begin
        // Capture happens this edge, so decode the pins directly
        if (releasePulse)
        begin
          if (rcms_pkg::rcms_decode(config_mode_select) == rcms_pkg::SRC_SCAN)
            state_nxt = rcms_pkg::ST_WAIT; // [R15]
          else
            state_nxt = rcms_pkg::ST_LOAD; // [R12] [R18]
        end
      end
      rcms_pkg::ST_WAIT:
        if (userLoadStart)
          state_nxt = rcms_pkg::ST_LOAD; // [R14] [R15]
      rcms_pkg::ST_LOAD:
        if (loadError && !spiActive)
          state_nxt = rcms_pkg::ST_FAIL;
        else if (loadDone)
          state_nxt = rcms_pkg::ST_DONE;
      rcms_pkg::ST_DONE:
        if (userLoadStart)
          state_nxt = rcms_pkg::ST_LOAD; // [R14]
      rcms_pkg::ST_FAIL:
        if (userLoadStart)
          state_nxt = rcms_pkg::ST_LOAD; // [R14]
      default:
        state_nxt = rcms_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_r <= rcms_pkg::ST_RESET;
    else if (coreReset)
      state_r <= rcms_pkg::ST_RESET; // [R1] [R4]
    else
      state_r <= state_nxt;
  end

  // Flash read kicks off on the single release edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flashReadStart_r <= 1'b0;
    else
      flashReadStart_r <= releasePulse &&
        (rcms_pkg::rcms_decode(config_mode_select) == rcms_pkg::SRC_ACTIVE); // [R18]
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      userLoad_r <= 1'b0;
    else if (coreReset)
      userLoad_r <= 1'b0;
    // Same states the machine leaves on a user request, so no stuck flag
    else if (userLoadStart && (state_r == rcms_pkg::ST_WAIT ||
      state_r == rcms_pkg::ST_DONE || state_r == rcms_pkg::ST_FAIL))
      userLoad_r <= 1'b1; // [R14]
    else if (state_r == rcms_pkg::ST_LOAD && (loadDone || loadError))
      userLoad_r <= 1'b0;
  end

  // ----------------------------------------
  // Progress outputs
  // ----------------------------------------
  // Active SPI retries on error, so failure only pulses failed
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cfgDone_r <= 1'b0;
    else
      cfgDone_r <= (state_nxt == rcms_pkg::ST_DONE || state_nxt == rcms_pkg::ST_FAIL)
        && !coreReset; // [R19]
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      failedDrive_r <= 1'b0;
    else if (coreReset)
      failedDrive_r <= 1'b0;
    else
      failedDrive_r <= (state_nxt == rcms_pkg::ST_FAIL) ||
        (state_r == rcms_pkg::ST_LOAD && loadError && spiActive); // [R19]
  end

  assign flashReadStart = flashReadStart_r;
  assign userLoadActive = userLoad_r;
  assign cfgDone = cfgDone_r;
  // Open drain: only pulls low, pull-up gives the high
  assign failedOut = 1'b0;
  assign failedOe = failedDrive_r; // [R19]
endmodule : rcms_top

// >>> tb/rcms_loader_model.sv
// Behavioural configuration data source on the far side of the block
`timescale 1ns/100ps
module rcms_loader_model (
  input wire logic clk_sys,
  input wire logic coreReset,
  input wire logic flashReadStart,
  input wire logic spiActive,
  input wire logic spiPassive,
  input wire logic userLoadActive,
  input wire logic failReq,
  output logic loadDone,
  output logic loadError
);
  logic [1:0] outHist = 2'b00;
  logic userPrev = 1'b0;
  logic retry = 1'b0;
  int waitCnt_r = 0;
  initial
  begin
    loadDone = 1'b0;
    loadError = 1'b0;
  end
  // Random delay covers both prompt and slow answers
  always @(negedge clk_sys)
  begin
    outHist <= {outHist[0], !coreReset};
    userPrev <= userLoadActive;
    if (coreReset)
    begin
      waitCnt_r <= 0;
      retry <= 1'b0;
      loadDone <= 1'b0;
      loadError <= 1'b0;
    end
    // Host starts a passive stream once the freshly captured mode shows
    else if (flashReadStart || (spiPassive && outHist == 2'b01) ||
      (userLoadActive && !userPrev))
    begin
      waitCnt_r <= 2 + $urandom_range(6);
      loadDone <= 1'b0;
      loadError <= 1'b0;
    end
    else if (waitCnt_r == 1)
    begin
      // Active SPI re-reads after an error; the second pass is clean
      waitCnt_r <= (failReq && spiActive && !retry) ? 3 : 0;
      retry <= failReq && spiActive && !retry;
      loadDone <= !failReq || retry;
      loadError <= failReq && !retry;
    end
    else
    begin
      if (waitCnt_r > 1)
        waitCnt_r <= waitCnt_r - 1;
      loadDone <= 1'b0;
      loadError <= 1'b0;
    end
  end
endmodule : rcms_loader_model

// >>> tb/rcms_chk.sv
// Concurrent checks on the mode select top level
`timescale 1ns/100ps
module rcms_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic porEnable,
  input wire logic supplyStable,
  input wire logic [3:0] config_mode_select,
  input wire logic loadDone,
  input wire logic loadError,
  input wire logic userLoadStart,
  input wire logic coreReset,
  input wire logic [3:0] modeHeld,
  input wire logic spiActive,
  input wire logic spiPassive,
  input wire logic scanMode,
  input wire logic spiPolarity,
  input wire logic spiPhase,
  input wire logic flashReadStart,
  input wire logic userLoadActive,
  input wire logic cfgDone,
  input wire logic failedOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence held_s;
    (resetPinN && (!porEnable || supplyStable)) [*4];
  endsequence
  // Two quiet cycles so the first captured value is settled
  sequence live_s;
    !coreReset && !$past(coreReset);
  endsequence
  a_pin_reset: assert property (!resetPinN |-> coreReset) else $error("pin low, no reset");
  a_supply_drop: assert property (porEnable && !supplyStable |-> coreReset) else $error("supply");
  a_release_sync: assert property (held_s |-> !coreReset) else $error("no release");
  a_mode_capture: assert property ($fell(coreReset) |=> modeHeld == $past(config_mode_select)) else $error("capture");
  a_mode_hold: assert property (live_s ##1 !coreReset |-> $stable(modeHeld)) else $error("mode moved");
  a_src_decode: assert property (live_s |-> {spiActive, spiPassive, scanMode} ==
    {modeHeld <= 4'h3, modeHeld[3:2] == 2'b01, modeHeld == 4'hC}) else $error("decode");
  a_clock_bits: assert property (live_s |-> {spiPolarity, spiPhase} ==
    ((spiActive || spiPassive) ? modeHeld[1:0] : 2'b00)) else $error("clock bits");
  a_flash_start: assert property ($rose(spiActive) |-> ##[0:1] flashReadStart) else $error("start");
  a_scan_idle: assert property (scanMode |-> !flashReadStart) else $error("scan started");
  a_done_load: assert property (spiPassive && loadDone && !loadError |-> ##[1:2] cfgDone) else $error("done");
  a_fail_flag: assert property (spiPassive && loadError |-> ##[1:2] (cfgDone && failedOe)) else $error("fail");
  a_user_load: assert property (live_s ##0 (scanMode && userLoadStart) |->
    ##[1:2] userLoadActive) else $error("user");
  a_fail_pulse: assert property (spiActive && loadError |=> failedOe ##1 !failedOe)
    else $error("no short fail pulse");
  a_flash_pulse: assert property (flashReadStart |=> !flashReadStart)
    else $error("start held");
endmodule : rcms_chk
bind rcms_top rcms_chk u_rcms_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .resetPinN(resetPinN),
  .porEnable(porEnable),
  .supplyStable(supplyStable),
  .config_mode_select(config_mode_select),
  .loadDone(loadDone),
  .loadError(loadError),
  .userLoadStart(userLoadStart),
  .coreReset(coreReset),
  .modeHeld(modeHeld),
  .spiActive(spiActive),
  .spiPassive(spiPassive),
  .scanMode(scanMode),
  .spiPolarity(spiPolarity),
  .spiPhase(spiPhase),
  .flashReadStart(flashReadStart),
  .userLoadActive(userLoadActive),
  .cfgDone(cfgDone),
  .failedOe(failedOe)
);

// >>> tb/tb.sv
// Self-checking bench for the mode select top level
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic resetPinN = 1'b0;
  logic porEnable = 1'b0; // Monitor off as when left open
  logic supplyStable = 1'b0;
  logic [3:0] config_mode_select = 4'h0;
  logic userLoadStart = 1'b0;
  logic failReq = 1'b0;
  logic [3:0] modeHeld;
  logic loadDone, loadError, coreReset, spiActive, spiPassive, scanMode, badMode;
  logic spiPolarity, spiPhase, flashReadStart, userLoadActive, cfgDone, failedOut, failedOe;
  wire failedIn = ~failedOe;
  int err_count = 0;
  int check_count = 0;
  // Only the nine legal codes reach the pins
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC};
  always #25 clk_sys = ~clk_sys;
  rcms_top u_rcms_top (
    .clk_sys(clk_sys),
    .rst(rst),
    .resetPinN(resetPinN),
    .porEnable(porEnable),
    .supplyStable(supplyStable),
    .config_mode_select(config_mode_select),
    .loadDone(loadDone),
    .loadError(loadError),
    .userLoadStart(userLoadStart),
    .failedIn(failedIn),
    .coreReset(coreReset),
    .modeHeld(modeHeld),
    .spiActive(spiActive),
    .spiPassive(spiPassive),
    .scanMode(scanMode),
    .badMode(badMode),
    .spiPolarity(spiPolarity),
    .spiPhase(spiPhase),
    .flashReadStart(flashReadStart),
    .userLoadActive(userLoadActive),
    .cfgDone(cfgDone),
    .failedOut(failedOut),
    .failedOe(failedOe)
  );
  rcms_loader_model u_rcms_loader_model (
    .clk_sys(clk_sys),
    .coreReset(coreReset),
    .flashReadStart(flashReadStart),
    .spiActive(spiActive),
    .spiPassive(spiPassive),
    .userLoadActive(userLoadActive),
    .failReq(failReq),
    .loadDone(loadDone),
    .loadError(loadError)
  );
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] exp_src(input logic [3:0] c);
    logic act;
    logic pas;
    act = c <= 4'h3;
    pas = c[3:2] == 2'b01;
    return {2'h0, !(act || pas || c == 4'hC), act, pas, c == 4'hC,
      (act || pas) ? c[1:0] : 2'b00};
  endfunction : exp_src
  task automatic boot(input logic [3:0] code);
    @(negedge clk_sys);
    resetPinN = 1'b0; // Reset before any load
    config_mode_select = code;
    repeat (2) @(negedge clk_sys);
    resetPinN = 1'b1; // Rising edge whatever the supplies; the por test raises it with supplies down
    repeat (5) @(negedge clk_sys);
    config_mode_select = codes[$urandom_range(8)];
  endtask : boot
  initial
  begin
    void'($urandom(32'h6CC82D93));
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    supplyStable = 1'b1;
    foreach (codes[i])
    begin
      // Active errors retry and end clean; passive errors stick as failed
      failReq = (codes[i] <= 4'h7) && $urandom_range(1);
      boot(codes[i]);
      check("mode", {4'h0, codes[i]}, {4'h0, modeHeld});
      check("source", exp_src(codes[i]),
        {2'h0, badMode, spiActive, spiPassive, scanMode, spiPolarity, spiPhase});
      userLoadStart = codes[i] == 4'hC;
      @(negedge clk_sys);
      userLoadStart = 1'b0;
      repeat (18) @(negedge clk_sys);
      check("status", {6'h0, 1'b1, failReq && codes[i][2]}, {6'h0, cfgDone, failedOe});
      check("failed level", 8'h00, {7'h0, failedOut});
    end
    failReq = 1'b0;
    porEnable = 1'b1;
    supplyStable = 1'b0;
    boot(4'h4);
    check("por hold", 8'h01, {7'h0, coreReset});
    supplyStable = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("por release", 8'h00, {7'h0, coreReset});
    supplyStable = 1'b0;
    @(negedge clk_sys);
    check("supply drop", 8'h01, {7'h0, coreReset});
    porEnable = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("monitor off", 8'h00, {7'h0, coreReset});
    wrap_up();
  end
  // Whole run is a few hundred cycles; generous margin
  initial
  begin
    #100us;
    err_count++;
    wrap_up();
  end
endmodule : tb
